/* hmap_map.svh */
/*
 Offsets, field positions, limits and retry counts of the defect map reader.
 Assumes byte offsets count from the first data byte of a map sector.
*/
`ifndef HMAP_MAP_SVH
`define HMAP_MAP_SVH

// ****************************************
// segment byte positions
// ****************************************
`define HMAP_MODEL_LAST 9'h006
`define HMAP_CYLS_HI 9'h007
`define HMAP_CYLS_LO 9'h008
`define HMAP_HEADS 9'h009
`define HMAP_SPT 9'h00A
`define HMAP_BPS_HI 9'h00B
`define HMAP_BPS_LO 9'h00C
`define HMAP_RSVD 9'h00D
`define HMAP_COUNT 9'h00E
`define HMAP_ENT_LAST 9'h0FE
`define HMAP_SEG_LAST 9'h0FF
`define HMAP_SEC_LAST 9'h1FF
`define HMAP_ENT_POS_LAST 3'h5

// ****************************************
// limits and codes
// ****************************************
`define HMAP_SEG_MAX 6'h28
`define HMAP_MAP_MAX 9'h140
`define HMAP_ALL_SEGS 8'hFF
`define HMAP_CYL_MID 16'h0336
`define HMAP_CYL_LAST_S 16'h042C
`define HMAP_CYL_LAST_L 16'h0533
`define HMAP_MAP_HEAD_MAX 8'h01
`define HMAP_CLEAN_HEAD_MAX 8'h02
`define HMAP_BURST_MAX 8'h0B
`define HMAP_TYPE_CORR 8'h00
`define HMAP_TYPE_UNC 8'h01
`define HMAP_LC_FIRST 8'h61
`define HMAP_LC_LAST 8'h7A

// ****************************************
// retry counts
// ****************************************
`define HMAP_RD_RETRIES 5'h10
`define HMAP_WR_TRIES 2'h3

`endif

/* hmap_pkg.sv */
/*
 Types of the defect map reader: states, addresses, entries, module state.
 Assumes hmap_map.svh supplies every number.
*/
package hmap_pkg;

   typedef enum logic [1:0] {HM_IDLE, HM_SEG, HM_PAD, HM_SCAN} hmap_state_t;

   typedef struct packed {
      logic [15:0] cyl;
      logic [7:0] head;
      logic [7:0] sect;
   } hmap_addr_t;

   typedef struct packed {
      hmap_addr_t addr;
      logic [7:0] len;
      logic [7:0] etype;
   } hmap_ent_t;

   typedef struct packed {
      hmap_state_t state;
      logic [8:0] idx;
      logic [2:0] seg;
      logic on_map;
      logic [7:0] sum;
      logic fmt;
      logic [5:0] cnt;
      logic [2:0] epos;
      logic [5:0] enr;
      hmap_ent_t ent;
      logic [8:0] seg_base;
      logic [8:0] wcnt;
      logic ovf;
      logic [7:0] loaded;
      logic [15:0] hdr_cyls;
      logic [7:0] hdr_heads;
      logic [7:0] hdr_spt;
      logic [15:0] hdr_bps;
      logic hdr_ok;
      logic def_v;
      hmap_ent_t def;
      logic def_unc;
      logic def_bad;
      logic seg_done;
      logic seg_ok;
      logic sum_err;
      logic fmt_err;
      hmap_addr_t q;
      logic [8:0] q_idx;
      logic q_hit;
      logic q_done;
      logic q_deny;
   } hmap_top_st_t;

   typedef struct packed {
      logic [4:0] rd_cnt;
      logic [1:0] wr_cnt;
      logic rd_retry;
      logic rd_recov;
      logic rd_unrec;
      logic wr_retry;
      logic wr_unrec;
   } hmap_rty_st_t;

endpackage

/* hmap_ent_if.sv */
/*
 Carrier of one assembled defect entry and its classification.
 Assumes the reader drives ent and the classifier answers combinationally.
*/
`timescale 1ns/100ps
interface hmap_ent_if import hmap_pkg::*; ();
   hmap_ent_t ent;
   logic uncorr;
   logic bad;
   modport asm (output ent, input uncorr, input bad);
   modport cls (input ent, output uncorr, output bad);
endinterface

/* hmap_classify.sv */
/*
 Combinational classifier of a defect entry by burst length and type code.
 Assumes a settled entry on the carrier; holds no state.
*/
`timescale 1ns/100ps
`include "hmap_map.svh"
module hmap_classify import hmap_pkg::*; (
   hmap_ent_if.cls eif
);
   logic long_burst;
   logic is_unc;
   logic is_corr;

   assign long_burst = eif.ent.len > `HMAP_BURST_MAX;
   assign is_unc = eif.ent.etype == `HMAP_TYPE_UNC;
   assign is_corr = eif.ent.etype == `HMAP_TYPE_CORR;
   // trust the worse of length and type, a host must not reuse a doubtful sector
   assign eif.uncorr = is_unc | long_burst;
   assign eif.bad = (!is_unc && !is_corr) || (is_unc != long_burst);
endmodule

/* hmap_retry.sv */
/*
 Read and write retry bookkeeping of the host controller.
 Assumes one attempt result pulse at a time per direction, same clock.
*/
`timescale 1ns/100ps
`include "hmap_map.svh"
module hmap_retry import hmap_pkg::*; (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic rd_att_i,
   input wire logic rd_good_i,
   input wire logic wr_vfy_i,
   input wire logic wr_good_i,
   output logic rd_retry_o,
   output logic rd_recov_o,
   output logic rd_unrec_o,
   output logic wr_retry_o,
   output logic wr_unrec_o
);
   hmap_rty_st_t st_r;
   hmap_rty_st_t st_nxt;

   always_comb begin
      st_nxt = st_r;
      st_nxt.rd_retry = 1'b0;
      st_nxt.rd_recov = 1'b0;
      st_nxt.rd_unrec = 1'b0;
      st_nxt.wr_retry = 1'b0;
      st_nxt.wr_unrec = 1'b0;
      if (rd_att_i) begin
         if (rd_good_i) begin
            st_nxt.rd_recov = st_r.rd_cnt != 5'h00;
            st_nxt.rd_cnt = 5'h00;
         end else if (st_r.rd_cnt == `HMAP_RD_RETRIES) begin
            st_nxt.rd_unrec = 1'b1;
            st_nxt.rd_cnt = 5'h00;
         end else begin
            st_nxt.rd_retry = 1'b1;
            st_nxt.rd_cnt = st_r.rd_cnt + 5'h01;
         end
      end
      if (wr_vfy_i) begin
         if (wr_good_i) begin
            st_nxt.wr_cnt = 2'h0;
         end else if (st_r.wr_cnt == `HMAP_WR_TRIES - 2'h1) begin
            st_nxt.wr_unrec = 1'b1;
            st_nxt.wr_cnt = 2'h0;
         end else begin
            st_nxt.wr_retry = 1'b1;
            st_nxt.wr_cnt = st_r.wr_cnt + 2'h1;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign rd_retry_o = st_r.rd_retry;
   assign rd_recov_o = st_r.rd_recov;
   assign rd_unrec_o = st_r.rd_unrec;
   assign wr_retry_o = st_r.wr_retry;
   assign wr_unrec_o = st_r.wr_unrec;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_wr_fail;
      wr_vfy_i && !wr_good_i;
   endsequence

   a_rd_unrec_limit: assert property (rd_unrec_o |-> $past(st_r.rd_cnt) == 5'h10)
      else $error("unrecoverable read flagged before sixteen retries");
   a_rd_recov_range: assert property (rd_recov_o |-> $past(st_r.rd_cnt) != 5'h00 && !rd_unrec_o)
      else $error("recoverable read flagged without a failed attempt");
   a_wr_third_fail: assert property (s_wr_fail ##0 (st_r.wr_cnt == 2'h2) |=> wr_unrec_o && !wr_retry_o)
      else $error("third failed write verify not reported unrecoverable");
endmodule

/* hmap_reader.sv */
/*
 Host side defect map reader: parses map sectors, keeps a table of
 uncorrectable sectors, guards writes and tracks retries.
 Assumes the byte stream, query and attempt inputs come from host logic on CLK_I.
*/
`timescale 1ns/100ps
`include "hmap_map.svh"
module hmap_reader import hmap_pkg::*; (
   input wire logic CLK_I,
   input wire logic RST_N_I,
   input wire logic BYTE_VALID_I,
   input wire logic [7:0] BYTE_I,
   input wire logic SECT_START_I,
   input wire logic [15:0] CYL_I,
   input wire logic [7:0] HEAD_I,
   input wire logic [7:0] SECTOR_I,
   input wire logic SEC512_I,
   input wire logic Q_REQ_I,
   output logic Q_READY_O,
   output logic Q_DONE_O,
   output logic Q_DENY_O,
   output logic DEF_VALID_O,
   output logic [15:0] DEF_CYL_O,
   output logic [7:0] DEF_HEAD_O,
   output logic [7:0] DEF_SECT_O,
   output logic [7:0] DEF_LEN_O,
   output logic DEF_UNCORR_O,
   output logic DEF_BAD_O,
   output logic SEG_DONE_O,
   output logic SEG_OK_O,
   output logic SUM_ERR_O,
   output logic FMT_ERR_O,
   output logic OVERFLOW_O,
   output logic [8:0] TOTAL_O,
   output logic MAP_SAVED_O,
   output logic HDR_VALID_O,
   output logic [15:0] HDR_CYLS_O,
   output logic [7:0] HDR_HEADS_O,
   output logic [7:0] HDR_SPT_O,
   output logic [15:0] HDR_BPS_O,
   input wire logic RD_ATT_I,
   input wire logic RD_GOOD_I,
   input wire logic WR_VFY_I,
   input wire logic WR_GOOD_I,
   output logic RD_RETRY_O,
   output logic RD_RECOV_O,
   output logic RD_UNREC_O,
   output logic WR_RETRY_O,
   output logic WR_UNREC_O
);
   hmap_top_st_t st_r;
   hmap_top_st_t st_nxt;
   hmap_addr_t qa;
   hmap_ent_t full;
   hmap_addr_t tbl_q;
   logic [7:0] sum_end;
   logic seg0;
   logic store;
   logic fin;
   logic tbl_we;
   // only uncorrectable sectors are kept, correctable ones stay usable
   logic [31:0] tbl [0:319];

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic ascii_ok(input logic [7:0] b);
      return !b[7] && !(b >= `HMAP_LC_FIRST && b <= `HMAP_LC_LAST);
   endfunction

   // before the header is known both possible last cylinders count as map tracks
   function automatic logic is_map(input hmap_addr_t a, input logic hok, input logic [15:0] hcyl);
      logic last;
      last = hok ? (a.cyl == hcyl - 16'h0001) : (a.cyl == `HMAP_CYL_LAST_S || a.cyl == `HMAP_CYL_LAST_L);
      return (a.cyl == 16'h0000 || a.cyl == `HMAP_CYL_MID || last) && a.head <= `HMAP_MAP_HEAD_MAX;
   endfunction

   assign qa = '{cyl: CYL_I, head: HEAD_I, sect: SECTOR_I};
   assign full = {st_r.ent[39:0], BYTE_I};
   assign sum_end = st_r.sum + BYTE_I;
   assign seg0 = st_r.seg == 3'h0;
   assign store = st_r.on_map && !st_r.loaded[st_r.seg];
   assign tbl_q = tbl[st_r.q_idx];

   hmap_ent_if eif ();
   assign eif.ent = full;

   hmap_classify u_cls (
      .eif(eif)
   );

   // ****************************************
   // parser and query engine
   // ****************************************
   always_comb begin
      st_nxt = st_r;
      fin = 1'b0;
      tbl_we = 1'b0;
      st_nxt.def_v = 1'b0;
      st_nxt.seg_done = 1'b0;
      st_nxt.q_done = 1'b0;
      if (BYTE_VALID_I && SECT_START_I && st_r.state != HM_SCAN) begin
         st_nxt.state = HM_SEG;
         st_nxt.idx = 9'h001;
         st_nxt.seg = SECTOR_I[2:0];
         st_nxt.on_map = is_map(qa, st_r.hdr_ok, st_r.hdr_cyls);
         st_nxt.sum = BYTE_I;
         st_nxt.fmt = (SECTOR_I[2:0] == 3'h0) && !ascii_ok(BYTE_I);
         st_nxt.cnt = 6'h00;
         st_nxt.epos = 3'h0;
         st_nxt.enr = 6'h00;
         st_nxt.seg_base = st_r.wcnt;
      end else begin
         case (st_r.state)
            HM_IDLE: begin
               if (Q_REQ_I) begin
                  st_nxt.state = HM_SCAN;
                  st_nxt.q = qa;
                  st_nxt.q_idx = 9'h000;
                  st_nxt.q_hit = is_map(qa, st_r.hdr_ok, st_r.hdr_cyls) && st_r.loaded != `HMAP_ALL_SEGS;
               end
            end
            HM_SEG: begin
               if (BYTE_VALID_I) begin
                  st_nxt.idx = st_r.idx + 9'h001;
                  st_nxt.sum = sum_end;
                  if (st_r.idx <= `HMAP_MODEL_LAST) begin
                     if (seg0 && !ascii_ok(BYTE_I)) begin
                        st_nxt.fmt = 1'b1;
                     end
                  end else if (st_r.idx == `HMAP_CYLS_HI) begin
                     if (seg0) begin
                        st_nxt.hdr_cyls[15:8] = BYTE_I;
                     end
                  end else if (st_r.idx == `HMAP_CYLS_LO) begin
                     if (seg0) begin
                        st_nxt.hdr_cyls[7:0] = BYTE_I;
                     end
                  end else if (st_r.idx == `HMAP_HEADS) begin
                     if (seg0) begin
                        st_nxt.hdr_heads = BYTE_I;
                     end
                  end else if (st_r.idx == `HMAP_SPT) begin
                     if (seg0) begin
                        st_nxt.hdr_spt = BYTE_I;
                     end
                  end else if (st_r.idx == `HMAP_BPS_HI) begin
                     if (seg0) begin
                        st_nxt.hdr_bps[15:8] = BYTE_I;
                     end
                  end else if (st_r.idx == `HMAP_BPS_LO) begin
                     if (seg0) begin
                        st_nxt.hdr_bps[7:0] = BYTE_I;
                     end
                  end else if (st_r.idx == `HMAP_RSVD) begin
                     if (seg0 && BYTE_I != 8'h00) begin
                        st_nxt.fmt = 1'b1;
                     end
                  end else if (st_r.idx == `HMAP_COUNT) begin
                     // an oversized count is flagged and clamped to the forty entries a segment holds
                     if (BYTE_I > {2'h0, `HMAP_SEG_MAX}) begin
                        st_nxt.fmt = 1'b1;
                        st_nxt.cnt = `HMAP_SEG_MAX;
                     end else begin
                        st_nxt.cnt = BYTE_I[5:0];
                     end
                  end else if (st_r.idx <= `HMAP_ENT_LAST) begin
                     st_nxt.ent = full;
                     if (st_r.epos == `HMAP_ENT_POS_LAST) begin
                        st_nxt.epos = 3'h0;
                        st_nxt.enr = st_r.enr + 6'h01;
                        if (st_r.enr < st_r.cnt) begin
                           st_nxt.def_v = 1'b1;
                           st_nxt.def = full;
                           st_nxt.def_unc = eif.uncorr;
                           st_nxt.def_bad = eif.bad;
                           if (eif.bad || (full.addr.cyl == 16'h0000 && full.addr.head <= `HMAP_CLEAN_HEAD_MAX)) begin
                              st_nxt.fmt = 1'b1;
                           end
                           if (store && eif.uncorr) begin
                              if (st_r.wcnt == `HMAP_MAP_MAX) begin
                                 st_nxt.ovf = 1'b1;
                              end else begin
                                 tbl_we = 1'b1;
                                 st_nxt.wcnt = st_r.wcnt + 9'h001;
                              end
                           end
                        end
                     end else begin
                        st_nxt.epos = st_r.epos + 3'h1;
                     end
                  end else if (SEC512_I) begin
                     st_nxt.state = HM_PAD;
                  end else begin
                     fin = 1'b1;
                  end
               end
            end
            HM_PAD: begin
               if (BYTE_VALID_I) begin
                  st_nxt.idx = st_r.idx + 9'h001;
                  if (BYTE_I != 8'h00) begin
                     st_nxt.fmt = 1'b1;
                  end
                  if (st_r.idx == `HMAP_SEC_LAST) begin
                     fin = 1'b1;
                  end
               end
            end
            HM_SCAN: begin
               if (st_r.q_hit || st_r.q_idx == st_r.wcnt) begin
                  st_nxt.q_done = 1'b1;
                  st_nxt.q_deny = st_r.q_hit;
                  st_nxt.state = HM_IDLE;
               end else begin
                  if (tbl_q == st_r.q) begin
                     st_nxt.q_hit = 1'b1;
                  end
                  st_nxt.q_idx = st_r.q_idx + 9'h001;
               end
            end
            default: begin
               st_nxt.state = HM_IDLE;
            end
         endcase
      end
      if (fin) begin
         st_nxt.state = HM_IDLE;
         st_nxt.seg_done = 1'b1;
         st_nxt.sum_err = st_nxt.sum != 8'h00;
         st_nxt.fmt_err = st_nxt.fmt;
         st_nxt.seg_ok = st_nxt.sum == 8'h00 && !st_nxt.fmt;
         if (st_nxt.seg_ok && st_r.on_map) begin
            st_nxt.loaded[st_r.seg] = 1'b1;
            if (seg0) begin
               st_nxt.hdr_ok = 1'b1;
            end
         end
         // a rejected segment gives back the table slots it took
         if (!st_nxt.seg_ok) begin
            st_nxt.wcnt = st_r.seg_base;
         end
      end
   end

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (tbl_we) begin
         tbl[st_r.wcnt] <= full.addr;
      end
   end

   // ****************************************
   // retries
   // ****************************************
   hmap_retry u_rty (
      .clk_i(CLK_I),
      .rst_n_i(RST_N_I),
      .rd_att_i(RD_ATT_I),
      .rd_good_i(RD_GOOD_I),
      .wr_vfy_i(WR_VFY_I),
      .wr_good_i(WR_GOOD_I),
      .rd_retry_o(RD_RETRY_O),
      .rd_recov_o(RD_RECOV_O),
      .rd_unrec_o(RD_UNREC_O),
      .wr_retry_o(WR_RETRY_O),
      .wr_unrec_o(WR_UNREC_O)
   );

   // ****************************************
   // outputs
   // ****************************************
   assign Q_READY_O = st_r.state == HM_IDLE;
   assign Q_DONE_O = st_r.q_done;
   assign Q_DENY_O = st_r.q_deny;
   assign DEF_VALID_O = st_r.def_v;
   assign DEF_CYL_O = st_r.def.addr.cyl;
   assign DEF_HEAD_O = st_r.def.addr.head;
   assign DEF_SECT_O = st_r.def.addr.sect;
   assign DEF_LEN_O = st_r.def.len;
   assign DEF_UNCORR_O = st_r.def_unc;
   assign DEF_BAD_O = st_r.def_bad;
   assign SEG_DONE_O = st_r.seg_done;
   assign SEG_OK_O = st_r.seg_ok;
   assign SUM_ERR_O = st_r.sum_err;
   assign FMT_ERR_O = st_r.fmt_err;
   assign OVERFLOW_O = st_r.ovf;
   assign TOTAL_O = st_r.wcnt;
   assign MAP_SAVED_O = st_r.loaded == `HMAP_ALL_SEGS;
   assign HDR_VALID_O = st_r.hdr_ok;
   assign HDR_CYLS_O = st_r.hdr_cyls;
   assign HDR_HEADS_O = st_r.hdr_heads;
   assign HDR_SPT_O = st_r.hdr_spt;
   assign HDR_BPS_O = st_r.hdr_bps;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RST_N_I);

   sequence s_last_byte;
      BYTE_VALID_I && !SECT_START_I && st_r.state == HM_SEG && st_r.idx == `HMAP_SEG_LAST && !SEC512_I;
   endsequence

   sequence s_map_query;
      Q_REQ_I && Q_READY_O && !SECT_START_I && is_map(qa, st_r.hdr_ok, st_r.hdr_cyls) && !MAP_SAVED_O;
   endsequence

   a_total_cap: assert property (TOTAL_O <= 9'h140)
      else $error("defect table beyond map capacity");
   a_count_cap: assert property (st_r.cnt <= 6'h28)
      else $error("segment entry count beyond forty");
   a_sum_check: assert property (s_last_byte |=> SEG_DONE_O && (SUM_ERR_O == ($past(sum_end) != 8'h00)))
      else $error("check sum verdict does not match segment sum");
   a_bad_rollback: assert property (SEG_DONE_O && !SEG_OK_O |-> TOTAL_O == st_r.seg_base)
      else $error("rejected segment left entries in the table");
   a_hdr_first: assert property ($rose(HDR_VALID_O) |-> SEG_DONE_O && SEG_OK_O && st_r.seg == 3'h0)
      else $error("header accepted from other than the first segment");
   a_burst_class: assert property (DEF_VALID_O && DEF_LEN_O > 8'h0B |-> DEF_UNCORR_O)
      else $error("long burst not classed uncorrectable");
   a_entry_gap: assert property (DEF_VALID_O |=> !DEF_VALID_O [*5])
      else $error("defect entries closer than six bytes");
   a_map_guard: assert property (s_map_query |-> ##[1:2] (Q_DONE_O && Q_DENY_O))
      else $error("map track write allowed before map saved");
   a_scan_bound: assert property (Q_REQ_I && Q_READY_O && !(BYTE_VALID_I && SECT_START_I) |-> ##[1:323] Q_DONE_O)
      else $error("write guard query did not finish");
endmodule

/* hmap_drive.sv */
/*
 Drive side model: serves map sector byte streams to the reader.
 Assumes the bench fills len_a and calls send between sectors.
*/
`timescale 1ns/100ps
module hmap_drive (
   input wire logic clk_i,
   output logic byte_valid_o,
   output logic [7:0] byte_o,
   output logic sect_start_o
);
   // arbitrary value
   parameter logic [55:0] MODEL_ID = "QZDRIVE";
   logic [7:0] len_a [40];
   // bytes sent per sector, 256 when the bench drops the 512-byte mode
   int nb = 512;
   logic [7:0] b [512];
   logic [7:0] s;
   logic [15:0] c;
   initial begin
      byte_valid_o = 1'b0;
      byte_o = 8'h00;
      sect_start_o = 1'b0;
   end
   // ****
   // one sector: header, entries, sum, pad
   // ****
   // one defect per track keeps track and surface limits
   task automatic send(input logic [2:0] seg, input logic [5:0] n, input logic bad);
      s = 8'h00;
      for (int i = 0; i < 512; i++) b[i] = 8'h00;
      if (seg == 3'h0) begin
         for (int i = 0; i < 7; i++) b[i] = MODEL_ID[8*(6-i)+:8];
         {b[7], b[8], b[9], b[10], b[11], b[12]} = {16'h042D, 8'h04, 8'h21, 16'h0200};
      end
      b[14] = {2'h0, n};
      for (int k = 0; k < n; k++) begin
         c = 16'h0100 + 16'h0028 * seg + k[15:0];
         {b[15+6*k], b[16+6*k], b[17+6*k]} = {c, 8'h03};
         {b[18+6*k], b[19+6*k], b[20+6*k]} = {5'h00, seg, len_a[k], 7'h00, len_a[k] > 8'h0B};
      end
      for (int i = 0; i < 255; i++) s = s + b[i];
      b[255] = 8'h00 - s + {7'h00, bad};
      for (int i = 0; i < nb; i++) begin
         @(posedge clk_i);
         byte_valid_o <= 1'b1;
         sect_start_o <= (i == 0);
         byte_o <= b[i];
      end
      @(posedge clk_i);
      byte_valid_o <= 1'b0;
      sect_start_o <= 1'b0;
      byte_o <= ~b[nb - 1];
   endtask
endmodule

/* tb_top.sv */
/*
 Self-checking bench of the defect map reader with a drive model.
 Assumes one 40 MHz clock and 512-byte sectors, then one last 256-byte sector.
*/
`timescale 1ns/100ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_total++; \
   $display("BAD t=%0t got=%0h exp=%0h", $time, a, b); end end
module tb_top;
   logic CLK_I, RST_N_I, BYTE_VALID_I, SECT_START_I, SEC512_I, Q_REQ_I, RD_ATT_I, RD_GOOD_I, WR_VFY_I, WR_GOOD_I;
   logic [7:0] BYTE_I, HEAD_I, SECTOR_I, DEF_LEN_O, DEF_HEAD_O, DEF_SECT_O, HDR_HEADS_O, HDR_SPT_O;
   logic [15:0] CYL_I, HDR_CYLS_O, HDR_BPS_O, DEF_CYL_O;
   logic [8:0] TOTAL_O;
   logic Q_READY_O, Q_DONE_O, Q_DENY_O, DEF_VALID_O, DEF_UNCORR_O, DEF_BAD_O, SEG_DONE_O, SEG_OK_O, OVERFLOW_O;
   logic SUM_ERR_O, FMT_ERR_O, MAP_SAVED_O, HDR_VALID_O, RD_RETRY_O, RD_RECOV_O, RD_UNREC_O, WR_RETRY_O, WR_UNREC_O;
   logic rt, fin;
   logic [5:0] n;
   int err_total, samples_checked, def_seen, seed, exp_tot, r;
   hmap_reader DUT (.CLK_I, .RST_N_I, .BYTE_VALID_I, .BYTE_I, .SECT_START_I, .CYL_I, .HEAD_I, .SECTOR_I,
      .SEC512_I, .Q_REQ_I, .Q_READY_O, .Q_DONE_O, .Q_DENY_O, .DEF_VALID_O, .DEF_CYL_O, .DEF_HEAD_O,
      .DEF_SECT_O, .DEF_LEN_O, .DEF_UNCORR_O, .DEF_BAD_O, .SEG_DONE_O, .SEG_OK_O, .SUM_ERR_O, .FMT_ERR_O,
      .OVERFLOW_O, .TOTAL_O, .MAP_SAVED_O, .HDR_VALID_O, .HDR_CYLS_O, .HDR_HEADS_O, .HDR_SPT_O,
      .HDR_BPS_O, .RD_ATT_I, .RD_GOOD_I, .WR_VFY_I, .WR_GOOD_I, .RD_RETRY_O, .RD_RECOV_O, .RD_UNREC_O,
      .WR_RETRY_O, .WR_UNREC_O);
   hmap_drive drv (.clk_i(CLK_I), .byte_valid_o(BYTE_VALID_I), .byte_o(BYTE_I), .sect_start_o(SECT_START_I));
   initial begin
      CLK_I = 1'b0;
      forever #12.5 CLK_I = ~CLK_I;
   end
   // address the drive model writes for entry k of segment sg
   function automatic logic [31:0] exp_addr(input logic [2:0] sg, input int k);
      return {16'h0100 + 16'h0028 * sg + k[15:0], 8'h03, 5'h00, sg};
   endfunction
   always @(negedge CLK_I) if (DEF_VALID_O === 1'b1) begin
      `CHK({DEF_CYL_O, DEF_HEAD_O, DEF_SECT_O}, exp_addr(SECTOR_I[2:0], def_seen))
      def_seen++;
      `CHK(DEF_UNCORR_O, DEF_LEN_O > 8'h0B)
      `CHK(DEF_BAD_O, 1'b0)
   end
   // ****
   // tasks
   // ****
   task results;
      $display("checked %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic wait_hi(input logic q);
      int i;
      for (i = 0; i < 400 && (q ? Q_DONE_O : SEG_DONE_O) !== 1'b1; i++) @(negedge CLK_I);
      if (i == 400) begin
         err_total++;
         results();
      end
   endtask
   // first two lengths sit on the burst boundary
   task automatic fill(input logic [5:0] m, input logic add);
      for (int k = 0; k < m; k++) begin
         r = $random(seed);
         drv.len_a[k] = (k == 0) ? 8'h0C : (k == 1) ? 8'h0B : {3'h0, r[4:0]} + 8'h01;
         if (add && drv.len_a[k] > 8'h0B) exp_tot++;
      end
   endtask
   task automatic sect(input logic [7:0] s, input logic [5:0] m, input logic bad);
      @(posedge CLK_I);
      CYL_I <= 16'h0000;
      HEAD_I <= 8'h00;
      SECTOR_I <= s;
      def_seen = 0;
      drv.send(s[2:0], m, bad);
      wait_hi(1'b0);
      `CHK({SEG_OK_O, SUM_ERR_O, FMT_ERR_O}, {~bad, bad, 1'b0})
      `CHK(def_seen, int'(m))
      `CHK(TOTAL_O, exp_tot[8:0])
   endtask
   task automatic query(input logic [15:0] c, input logic [7:0] h, input logic d);
      @(posedge CLK_I);
      CYL_I <= c;
      HEAD_I <= h;
      SECTOR_I <= 8'h00;
      Q_REQ_I <= 1'b1;
      @(posedge CLK_I);
      Q_REQ_I <= 1'b0;
      @(negedge CLK_I);
      `CHK(Q_READY_O, 1'b0)
      wait_hi(1'b1);
      `CHK(Q_DENY_O, d)
   endtask
   task automatic att(input logic w, input logic g);
      @(posedge CLK_I);
      {RD_ATT_I, RD_GOOD_I, WR_VFY_I, WR_GOOD_I} <= w ? {2'b00, 1'b1, g} : {1'b1, g, 2'b00};
      @(posedge CLK_I);
      {RD_ATT_I, WR_VFY_I} <= 2'b00;
      @(negedge CLK_I);
      rt = w ? WR_RETRY_O : RD_RETRY_O;
      fin = w ? WR_UNREC_O : (g ? RD_RECOV_O : RD_UNREC_O);
   endtask
   // ****
   // main sequence
   // ****
   initial begin
      {seed, err_total, samples_checked, exp_tot, def_seen} = {32'd326, 128'd0};
      {RST_N_I, SEC512_I, Q_REQ_I, RD_ATT_I, RD_GOOD_I, WR_VFY_I, WR_GOOD_I} = 7'b0100000;
      {CYL_I, HEAD_I, SECTOR_I} = 32'h0;
      repeat (10) @(posedge CLK_I);
      `CHK({Q_READY_O, TOTAL_O, MAP_SAVED_O}, {1'b1, 9'h000, 1'b0})
      RST_N_I <= 1'b1;
      query(16'h0336, 8'h01, 1'b1);
      fill(6'h05, 1'b0);
      sect(8'h02, 6'h05, 1'b1);
      for (int g = 0; g < 8; g++) begin
         r = $random(seed);
         n = (g == 0) ? 6'h28 : {1'b0, r[4:0]} + {3'h0, r[7:5]};
         fill(n, 1'b1);
         sect({5'h00, g[2:0]}, n, 1'b0);
      end
      `CHK({MAP_SAVED_O, HDR_VALID_O, HDR_CYLS_O, HDR_BPS_O}, {2'b11, 16'h042D, 16'h0200})
      `CHK({OVERFLOW_O, HDR_HEADS_O, HDR_SPT_O}, {1'b0, 8'h04, 8'h21})
      // a 256-byte sector ends the segment at byte 255
      @(posedge CLK_I);
      SEC512_I <= 1'b0;
      drv.nb = 256;
      fill(6'h03, 1'b0);
      sect(8'h09, 6'h03, 1'b1);
      query(16'h0100, 8'h03, 1'b1);
      query(16'h0101, 8'h03, 1'b0);
      query(16'h0336, 8'h01, 1'b0);
      for (int i = 0; i < 17; i++) begin
         att(1'b0, 1'b0);
         `CHK({rt, fin}, (i < 16) ? 2'b10 : 2'b01)
      end
      att(1'b0, 1'b0);
      att(1'b0, 1'b1);
      `CHK({rt, fin}, 2'b01)
      for (int i = 0; i < 3; i++) begin
         att(1'b1, 1'b0);
         `CHK({rt, fin}, (i < 2) ? 2'b10 : 2'b01)
      end
      att(1'b1, 1'b1);
      `CHK({rt, fin}, 2'b00)
      results();
   end
endmodule
